/* File: dbs_map.svh */
// dbs_map.svh: offsets, reset values and clamp values of the debug programming port
// assumes: included by the port package and modules of the block
`ifndef DBS_MAP_SVH
`define DBS_MAP_SVH
`define DBS_ADDR_MSB 31
`define DBS_ADDR_LSB 2
`define DBS_DATA_W 32
`define DBS_REG_CNT 4
`define DBS_IDX_W 2
`define DBS_OFF_CTRL 30'h0000000
`define DBS_OFF_DATA 30'h0000001
`define DBS_OFF_HALF 30'h0000002
`define DBS_OFF_STAT 30'h0000003
`define DBS_RST_WORD 32'h00000000
`define DBS_CLAMP_READY 1'b1
`define DBS_CLAMP_RDATA 32'h00000000
`define DBS_CLAMP_ERROR 1'b1
`define DBS_WAIT_CNT 2'h1
`endif

/* File: dbs_pkg.sv */
// dbs_pkg.sv: types shared by the debug programming port
// assumes: dbs_map.svh sits in the same folder
`include "dbs_map.svh"
package dbs_pkg;
  typedef struct packed {
    logic select;
    logic accessPhase;
    logic writeDir;
    logic [`DBS_ADDR_MSB:`DBS_ADDR_LSB] wordAddr;
    logic [`DBS_DATA_W-1:0] wrData;
  } dbs_req_type;
  typedef struct packed {
    logic ready;
    logic error;
    logic [`DBS_DATA_W-1:0] rdData;
  } dbs_rsp_type;
  typedef enum logic [1:0] {
    DBS_IDLE = 2'b00,
    DBS_WAIT = 2'b01,
    DBS_DONE = 2'b10
  } dbs_state_type;
endpackage : dbs_pkg

/* File: dbs_reg_file.sv */
// dbs_reg_file.sv: four words of register storage with 8/16/32-bit widths
// assumes: one write strobe per cycle from the bus port
`timescale 1ns/10ps
`include "dbs_map.svh"
module dbs_reg_file
  import dbs_pkg::*;
#(
  parameter int DATA_W = `DBS_DATA_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wrEn,
  input wire logic [`DBS_IDX_W-1:0] wrIdx,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic [`DBS_IDX_W-1:0] rdIdx,
  output logic [DATA_W-1:0] rdData
);
  logic [DATA_W-1:0] store [`DBS_REG_CNT];
  logic [DATA_W-1:0] next_store [`DBS_REG_CNT];

  // register widths: idx0 32 bits, idx1 8 bits, idx2 16 bits, idx3 status (read only)
  function automatic logic [DATA_W-1:0] widthMask(input logic [`DBS_IDX_W-1:0] idx);
    case (idx)
      2'h0: widthMask = {DATA_W{1'b1}};
      2'h1: widthMask = DATA_W'(32'h000000ff);
      2'h2: widthMask = DATA_W'(32'h0000ffff);
      default: widthMask = '0;
    endcase
  endfunction : widthMask

  always_comb begin
    for (int i = 0; i < `DBS_REG_CNT; i++) begin
      next_store[i] = store[i];
    end
    if (wrEn) begin
      next_store[wrIdx] = wrData & widthMask(wrIdx);
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < `DBS_REG_CNT; i++) begin
      if (!rst_b) begin
        store[i] <= DATA_W'(`DBS_RST_WORD);
      end else begin
        store[i] <= next_store[i];
      end
    end
  end

  assign rdData = store[rdIdx] & widthMask(rdIdx);
endmodule : dbs_reg_file

/* File: dbs_debug_port.sv */
// dbs_debug_port.sv: slave side of the debug programming bus, with clamping
// assumes: one master drives select, phase, direction, address and data on clk_sys
`timescale 1ns/10ps
`include "dbs_map.svh"

// What this block does
// - sample and advance only on rising clock
// - low reset returns port to idle
// - word address bits 31:2, only bit 31 ignored
// - write direction high writes, low reads
// - ready low stretches the transfer
// - selected slave drives read data
// - error valid in second transfer cycle
// - error only when component unavailable
// - clamp ready 1, data 0, error 1
// - bus and register model 32 bits
// - registers may be 8, 16, 32 bits
// - address bit 31 not split map
// - other paths only alongside bus access
module dbs_debug_port
  import dbs_pkg::*;
#(
  parameter int DATA_W = `DBS_DATA_W,
  parameter logic [1:0] WAIT_CNT = `DBS_WAIT_CNT
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire dbs_req_type busReq,
  input wire logic compPowered,
  input wire logic compEnabled,
  output dbs_rsp_type busRsp,
  output logic [DATA_W-1:0] ctrlWord
);
  dbs_state_type state, next_state;
  logic [1:0] waitCnt, next_waitCnt;
  dbs_rsp_type next_busRsp;
  logic [DATA_W-1:0] next_ctrlWord;
  logic [DATA_W-1:0] rfData;
  logic [`DBS_IDX_W-1:0] idx;
  logic available, wrEn, mapped;
  logic [DATA_W-1:0] statusWord;

  assign available = compPowered & compEnabled;
  // word-address bits 3:2 pick the word and bits 30:4 must be zero; bit 31 carries no special meaning
  assign idx = busReq.wordAddr[`DBS_ADDR_LSB+`DBS_IDX_W-1:`DBS_ADDR_LSB];
  assign mapped = (busReq.wordAddr[`DBS_ADDR_MSB-1:`DBS_ADDR_LSB+`DBS_IDX_W] == '0);
  assign statusWord = DATA_W'({state, available});

  dbs_reg_file #(.DATA_W(DATA_W)) regFile (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wrEn(wrEn),
    .wrIdx(idx),
    .wrData(busReq.wrData),
    .rdIdx(idx),
    .rdData(rfData)
  );

  always_comb begin
    next_state = state;
    next_waitCnt = waitCnt;
    next_busRsp = busRsp;
    next_ctrlWord = ctrlWord;
    wrEn = 1'b0;
    if (!available) begin
      next_state = DBS_IDLE;
      next_busRsp.ready = `DBS_CLAMP_READY;
      next_busRsp.rdData = DATA_W'(`DBS_CLAMP_RDATA);
      next_busRsp.error = `DBS_CLAMP_ERROR;
    end else begin
      next_busRsp.error = 1'b0;
      case (state)
        DBS_IDLE: begin
          next_busRsp.ready = 1'b0;
          next_busRsp.rdData = '0;
          if (busReq.select && !busReq.accessPhase) begin
            next_waitCnt = WAIT_CNT;
            next_state = DBS_WAIT;
          end
        end
        DBS_WAIT: begin
          if (waitCnt != 2'h0) begin
            next_waitCnt = waitCnt - 2'h1;
          end else begin
            next_busRsp.ready = 1'b1;
            next_state = DBS_DONE;
            if (busReq.writeDir) begin
              wrEn = mapped && (idx != 2'h3);
              if (mapped && idx == 2'h0) begin
                next_ctrlWord = busReq.wrData;
              end
            end else if (!mapped) begin
              next_busRsp.rdData = '0;
            end else if (idx == 2'h3) begin
              next_busRsp.rdData = statusWord;
            end else begin
              next_busRsp.rdData = rfData;
            end
          end
        end
        DBS_DONE: begin
          next_busRsp.ready = 1'b0;
          next_busRsp.rdData = '0;
          next_state = DBS_IDLE;
        end
        default: begin
          next_state = DBS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= DBS_IDLE;
      waitCnt <= 2'h0;
      busRsp <= '0;
      ctrlWord <= '0;
    end else begin
      state <= next_state;
      waitCnt <= next_waitCnt;
      busRsp <= next_busRsp;
      ctrlWord <= next_ctrlWord;
    end
  end

  // consecutive busy cycles and the completing cycle, used only by the checks
  logic [2:0] busyCnt, next_busyCnt;
  logic finishing;

  assign finishing = available && state == DBS_WAIT && waitCnt == 2'h0;

  always_comb begin
    next_busyCnt = busyCnt;
    if (state == DBS_IDLE) begin
      next_busyCnt = 3'h0;
    end else if (busyCnt != 3'h7) begin
      next_busyCnt = busyCnt + 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      busyCnt <= 3'h0;
    end else begin
      busyCnt <= next_busyCnt;
    end
  end

  // checks
  reset_idle_a: assert property (@(posedge clk_sys) !rst_b |=> state == DBS_IDLE
      && !busRsp.ready)
    else $error("port not idle after reset");
  reset_clear_a: assert property (@(posedge clk_sys) !rst_b |=> !busRsp.error
      && busRsp.rdData == '0 && ctrlWord == '0)
    else $error("outputs not cleared by reset");
  clamp_values_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !available |=> busRsp.ready && busRsp.error && busRsp.rdData == '0)
    else $error("outputs not clamped");
  off_nowrite_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !available |-> !wrEn)
    else $error("write while unavailable");
  error_cause_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      busRsp.error |-> $past(available) == 1'b0)
    else $error("error raised while available");
  error_free_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      available |=> !busRsp.error)
    else $error("error while component available");
  ready_time_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (available && state == DBS_IDLE && busReq.select && !busReq.accessPhase)
      ##1 available [*3] |-> busRsp.ready)
    else $error("ready not at expected cycle");
  ready_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      busRsp.ready && available && $past(available) |=> !busRsp.ready || !available)
    else $error("ready held beyond one cycle");
  wait_stretch_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      available && state == DBS_WAIT && waitCnt != 2'h0 |=> !busRsp.ready)
    else $error("ready raised during wait states");
  ready_within_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      available && state == DBS_WAIT |-> ##[1:4] (busRsp.ready || !available))
    else $error("transfer not completed in time");
  done_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      state == DBS_DONE |=> state == DBS_IDLE)
    else $error("port not idle after completion");
  busy_bound_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      busyCnt <= 3'h5)
    else $error("port busy too long");
  setup_take_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      available && state == DBS_IDLE && busReq.select && !busReq.accessPhase
      |=> state == DBS_WAIT)
    else $error("setup cycle not taken");
  idle_ignore_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      available && state == DBS_IDLE && !busReq.select |=> state == DBS_IDLE)
    else $error("transfer started without select");
  error_second_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(busRsp.error) |-> !$past(available))
    else $error("error not tied to unavailability");
  write_store_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wrEn && idx == 2'h0 |=> ctrlWord == $past(busReq.wrData))
    else $error("control word not written");
  ctrl_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !wrEn |=> $stable(ctrlWord))
    else $error("control word changed without write");
  status_ro_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wrEn |-> idx != 2'h3 && mapped)
    else $error("write to read-only or unmapped word");
  read_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      available && $past(available) && !busRsp.ready |-> busRsp.rdData == '0)
    else $error("read data driven outside completion");
  write_rdzero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      finishing && busReq.writeDir |=> busRsp.ready && busRsp.rdData == '0)
    else $error("read data driven on a write");
  status_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      finishing && !busReq.writeDir && mapped && idx == 2'h3
      |=> busRsp.rdData == DATA_W'({DBS_WAIT, 1'b1}))
    else $error("status word wrong");
  unmapped_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      finishing && !busReq.writeDir && !mapped
      |=> busRsp.ready && busRsp.rdData == '0 && !busRsp.error)
    else $error("unmapped read not empty");
  write_cov_c: cover property (@(posedge clk_sys) wrEn);
  read_cov_c: cover property (@(posedge clk_sys) busRsp.ready && !busReq.writeDir && available);
  clamp_cov_c: cover property (@(posedge clk_sys) $fell(available));
  stall_cov_c: cover property (@(posedge clk_sys) state == DBS_WAIT && waitCnt != 2'h0);
  error_cov_c: cover property (@(posedge clk_sys) busRsp.error && busReq.accessPhase);
endmodule : dbs_debug_port

/* File: dbs_bus_master.sv */
// dbs_bus_master.sv: behavioural master of the debug programming bus
// assumes: dbs_pkg compiled first; the bench calls xfer
`timescale 1ns/10ps
module dbs_bus_master
  import dbs_pkg::*;
(
  input wire logic clk_sys,
  input wire dbs_rsp_type busRsp,
  output dbs_req_type busReq
);
  initial begin
    busReq = '0;
  end
  // setup cycle, then access cycles until ready
  task automatic xfer(input logic wr, input logic [29:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output int n);
    logic rdy;
    repeat (2) @(posedge clk_sys);
    #2;
    busReq.select = 1'b1;
    busReq.accessPhase = 1'b0;
    busReq.writeDir = wr;
    busReq.wordAddr = addr;
    busReq.wrData = wr ? wd : ~busReq.wrData;
    @(posedge clk_sys);
    #2;
    busReq.accessPhase = 1'b1;
    n = 0;
    // answer read mid-cycle where settled; request holds through the completing edge
    do begin
      @(negedge clk_sys);
      n++;
      rdy = busRsp.ready;
      rd = busRsp.rdData;
      err = busRsp.error;
      @(posedge clk_sys);
    end while (rdy !== 1'b1 && n < 50);
    #2;
    busReq.select = 1'b0;
    busReq.accessPhase = 1'b0;
    // released lines do not keep their last value
    busReq.wordAddr = ~busReq.wordAddr;
    busReq.wrData = ~busReq.wrData;
  endtask : xfer
endmodule : dbs_bus_master

/* File: tb_top.sv */
// tb_top.sv: self-checking bench of the debug programming port
// assumes: design files and dbs_bus_master compiled first
`timescale 1ns/10ps
module tb_top
  import dbs_pkg::*;
;
  localparam logic [1:0] WAIT = 2'h1;
  logic clk_sys, rst_b, compPowered, compEnabled, errv;
  dbs_req_type busReq;
  dbs_rsp_type busRsp;
  logic [31:0] ctrlWord, rdv;
  int n_errors = 0, checks = 0, cycles = 0, nv;
  dbs_debug_port #(.WAIT_CNT(WAIT)) dbs_debug_port_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .busReq(busReq), .compPowered(compPowered), .compEnabled(compEnabled),
    .busRsp(busRsp), .ctrlWord(ctrlWord));
  dbs_bus_master dbs_bus_master_inst (.clk_sys(clk_sys), .busRsp(busRsp), .busReq(busReq));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic go(input logic wr, input logic [29:0] a, input logic [31:0] d);
    dbs_bus_master_inst.xfer(wr, a, d, rdv, errv, nv);
    chk("finished", 32'(nv < 50), 32'h1);
  endtask : go
  task automatic t_rst;
    chk("ready", busRsp.ready, 32'h0);
    chk("error", busRsp.error, 32'h0);
    chk("ctrlWord", ctrlWord, 32'h0);
    chk("rdData", busRsp.rdData, 32'h0);
  endtask : t_rst
  task automatic t_full;
    go(1'b1, 30'h0, 32'ha5c31e7f);
    chk("waits", nv, 32'(WAIT) + 32'h2);
    chk("ctrlWord", ctrlWord, 32'ha5c31e7f);
    go(1'b0, 30'h0, 32'h0);
    chk("rd0", rdv, 32'ha5c31e7f);
    chk("err", errv, 32'h0);
  endtask : t_full
  task automatic t_width;
    logic [31:0] exp [1:2] = '{32'h000000ff, 32'h0000ffff};
    for (int i = 1; i <= 2; i++) begin
      go(1'b1, 30'(i), 32'hffffffff);
      go(1'b0, 30'(i), 32'h0);
      chk("narrow", rdv, exp[i]);
    end
    go(1'b1, 30'h3, 32'hffffffff);
    go(1'b0, 30'h3, 32'h0);
    chk("status", rdv, 32'({DBS_WAIT, 1'b1}));
    chk("roKept", ctrlWord, 32'ha5c31e7f);
  endtask : t_width
  task automatic t_map;
    go(1'b1, 30'h20000000, 32'h12345678);
    chk("bit31", ctrlWord, 32'h12345678);
    go(1'b1, 30'h10, 32'hdeadbeef);
    go(1'b0, 30'h10, 32'h0);
    chk("unmapped", rdv, 32'h0);
    chk("unmapErr", errv, 32'h0);
    chk("kept", ctrlWord, 32'h12345678);
  endtask : t_map
  task automatic t_clamp(input logic pw, input logic en);
    compPowered = pw;
    compEnabled = en;
    repeat (2) @(posedge clk_sys);
    go(1'b1, 30'h0, 32'h0f0f0f0f);
    chk("offWait", nv, 32'h1);
    chk("offErr", errv, 32'h1);
    chk("offRd", rdv, 32'h0);
    chk("offKept", ctrlWord, 32'h12345678);
    compPowered = 1'b1;
    compEnabled = 1'b1;
    repeat (2) @(posedge clk_sys);
    #2;
  endtask : t_clamp
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    rst_b = 1'b0;
    compPowered = 1'b1;
    compEnabled = 1'b1;
    repeat (2) @(posedge clk_sys);
    #2 rst_b = 1'b1;
    t_rst();
    t_full();
    t_width();
    t_map();
    t_clamp(1'b0, 1'b1);
    t_clamp(1'b1, 1'b0);
    @(posedge clk_sys);
    #2 rst_b = 1'b0;
    repeat (2) @(posedge clk_sys);
    #2 rst_b = 1'b1;
    t_rst();
    wrap_up();
  end
endmodule : tb_top
